// >>> hdl/cpr_core_regs.sv
// Core register set: accumulator, data pointer, stack location register and status word behind APB.
`timescale 1ns/1ns
`default_nettype none


module cpr_core_regs
  import cpr_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [2:0]        op_code,
  input  wire logic [7:0]        op_operand,
  input  wire logic              stack_push,
  input  wire logic              stack_pop,
  output logic      [7:0]        stack_access_addr,
  output logic      [7:0]        accumulator,
  output logic      [7:0]        result_high,
  output logic      [15:0]       data_pointer,
  output logic      [7:0]        program_status_word,
  output logic      [4:0]        bank_base_addr
);

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  // The index decode needs byte address bits up to 9, and at least one bit above them
  // must exist so that the upper-bits-zero test has a legal slice to look at.
  if (ADDR_W < 11) begin : g_addr_check
    $error("cpr_core_regs: ADDR_W must be at least 11");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  // Stack and data pointer bytes.
  logic [7:0] stack_location_register;

  logic [7:0] pointer_low;

  logic [7:0] pointer_high;

  // Arithmetic result bytes.
  logic [7:0] acc_q;

  logic [7:0] high_q;

  // Status word bits, kept as separate flops so each has its own writer.
  logic       carry_flag;

  logic       half_carry_flag;

  logic       user_flag_a;

  logic       bank_select_high;

  logic       bank_select_low;

  logic       overflow_flag;

  logic       user_flag_b;

  logic       parity_q;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  // Any address with stray low or high bits is refused rather than aliased.
  wire logic [7:0] reg_index   = paddr[9:2];

  wire logic       aligned     = (paddr[1:0] == 2'h0) && (paddr[ADDR_W-1:10] == '0);

  wire logic       hit_stack   = aligned && (reg_index == CPR_IDX_STACK_TOP);
  wire logic       hit_dp_low  = aligned && (reg_index == CPR_IDX_DP_LOW);
  wire logic       hit_dp_high = aligned && (reg_index == CPR_IDX_DP_HIGH);
  wire logic       hit_psw     = aligned && (reg_index == CPR_IDX_PSW);
  wire logic       hit_acc     = aligned && (reg_index == CPR_IDX_ACC);
  wire logic       hit_high    = aligned && (reg_index == CPR_IDX_RESULT_HI);
  wire logic       hit_any     = hit_stack || hit_dp_low || hit_dp_high || hit_psw || hit_acc || hit_high;
  wire logic       setup_phase = psel && !penable;
  wire logic       wr_commit   = psel && penable && pready && pwrite && !pslverr && pstrb[0];
  wire logic [7:0] wbyte       = pwdata[7:0];

  // A stable status word image; parity is the live flop, so writes never touch it.
  wire logic [7:0] psw_image   = {carry_flag, half_carry_flag, user_flag_a, bank_select_high,
                                  bank_select_low, overflow_flag, user_flag_b, parity_q};

  logic [7:0] read_byte;
  always_comb begin
    if (hit_stack) begin
      read_byte = stack_location_register;
    end else if (hit_dp_low) begin
      read_byte = pointer_low;
    end else if (hit_dp_high) begin
      read_byte = pointer_high;
    end else if (hit_psw) begin
      read_byte = psw_image;
    end else if (hit_acc) begin
      read_byte = acc_q;
    end else if (hit_high) begin
      read_byte = high_q;
    end else begin
      read_byte = 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Arithmetic on the accumulator
  // ----------------------------------------------------------------
  wire logic       op_add  = (op_code == CPR_OP_ADD) || (op_code == CPR_OP_ADD_CARRY);
  wire logic       op_sub  = (op_code == CPR_OP_SUB_BORROW);
  wire logic       op_mul  = (op_code == CPR_OP_MULTIPLY);
  wire logic       op_div  = (op_code == CPR_OP_DIVIDE);
  wire logic       op_any  = op_add || op_sub || op_mul || op_div;
  wire logic       cin     = (op_code == CPR_OP_ADD_CARRY || op_sub) ? carry_flag : 1'b0;
  wire logic [8:0] cin9    = {8'h00, cin};
  wire logic [4:0] cin5    = {4'h0, cin};
  wire logic [8:0] sum9    = {1'b0, acc_q} + {1'b0, op_operand} + cin9;
  wire logic [4:0] sum5    = {1'b0, acc_q[3:0]} + {1'b0, op_operand[3:0]} + cin5;
  wire logic [8:0] dif9    = {1'b0, acc_q} - {1'b0, op_operand} - cin9;
  wire logic [4:0] dif5    = {1'b0, acc_q[3:0]} - {1'b0, op_operand[3:0]} - cin5;
  wire logic [15:0] prod16 = acc_q * op_operand;
  wire logic       div_zero = (op_operand == 8'h00);
  wire logic [7:0] quot    = div_zero ? acc_q : acc_q / op_operand;
  wire logic [7:0] remd    = div_zero ? high_q : acc_q % op_operand;
  wire logic       add_ovf = (acc_q[7] == op_operand[7]) && (sum9[7] != acc_q[7]);
  wire logic       sub_ovf = (acc_q[7] != op_operand[7]) && (dif9[7] != acc_q[7]);

  logic [7:0] arith_acc;
  logic [7:0] arith_high;
  logic       arith_carry;
  logic       arith_half;
  logic       arith_ovf;
  always_comb begin
    arith_acc   = acc_q;
    arith_high  = high_q;
    arith_carry = 1'b0;
    arith_half  = 1'b0;
    arith_ovf   = 1'b0;
    if (op_add) begin
      arith_acc   = sum9[7:0];
      arith_carry = sum9[8];
      arith_half  = sum5[4];
      arith_ovf   = add_ovf;
    end else if (op_sub) begin
      arith_acc   = dif9[7:0];
      arith_carry = dif9[8];
      arith_half  = dif5[4];
      arith_ovf   = sub_ovf;
    end else if (op_mul) begin
      arith_acc   = prod16[7:0];
      arith_high  = prod16[15:8];
      arith_ovf   = (prod16[15:8] != 8'h00);
    end else if (op_div) begin
      arith_acc   = quot;
      arith_high  = remd;
      arith_ovf   = div_zero;
    end
  end

  // ----------------------------------------------------------------
  // Next values; core activity takes precedence over a bus write
  // ----------------------------------------------------------------
  wire logic       wr_stack = wr_commit && hit_stack;
  wire logic       wr_psw   = wr_commit && hit_psw;
  wire logic       wr_acc   = wr_commit && hit_acc;
  wire logic       wr_high  = wr_commit && hit_high;
  wire logic [7:0] stack_up = stack_location_register + 8'h01;
  wire logic [7:0] stack_dn = stack_location_register - 8'h01;

  logic [7:0] next_stack;
  logic [7:0] next_stack_addr;
  logic [7:0] next_acc;
  logic [7:0] next_high;
  logic       next_carry;
  logic       next_half;
  logic       next_ovf;

  // A push wins over a pop in the same cycle, and both win over a bus write.
  // The access address is the slot to write after a push and the slot to read on a pop.
  always_comb begin
    next_stack      = stack_location_register;
    next_stack_addr = stack_access_addr;
    if (stack_push) begin
      next_stack      = stack_up;
      next_stack_addr = stack_up;
    end else if (stack_pop) begin
      next_stack      = stack_dn;
      next_stack_addr = stack_location_register;
    end else if (wr_stack) begin
      next_stack      = wbyte;
    end
  end

  // Core arithmetic wins over a bus write to the same register, since the
  // instruction stream must never lose a result to a late software store.
  always_comb begin
    next_acc   = acc_q;
    next_high  = high_q;
    next_carry = carry_flag;
    next_half  = half_carry_flag;
    next_ovf   = overflow_flag;
    if (op_any) begin
      next_acc   = arith_acc;
      next_high  = arith_high;
      next_carry = arith_carry;
      next_half  = arith_half;
      next_ovf   = arith_ovf;
    end else begin
      if (wr_acc) begin
        next_acc = wbyte;
      end
      if (wr_high) begin
        next_high = wbyte;
      end
      if (wr_psw) begin
        next_carry = wbyte[CPR_PSW_CARRY];
        next_half  = wbyte[CPR_PSW_HALF];
        next_ovf   = wbyte[CPR_PSW_OVERFLOW];
      end
    end
  end

  // Parity follows the value the accumulator is about to take, so it never lags it.
  wire logic       next_parity = ^next_acc;

  // ----------------------------------------------------------------
  // APB response
  // ----------------------------------------------------------------
  // Answer is registered in the setup cycle so the access phase sees it at once.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup_phase;
      pslverr <= setup_phase && !hit_any;
      prdata  <= (setup_phase && !pwrite) ? {24'h00_0000, read_byte} : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Stack and data pointer
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stack_location_register <= CPR_RST_STACK_TOP;
      stack_access_addr       <= CPR_RST_STACK_TOP;
      pointer_low             <= CPR_RST_DP_LOW;
      pointer_high            <= CPR_RST_DP_HIGH;
    end else begin
      stack_location_register <= next_stack;
      stack_access_addr       <= next_stack_addr;
      if (wr_commit && hit_dp_low) begin
        pointer_low <= wbyte;
      end
      if (wr_commit && hit_dp_high) begin
        pointer_high <= wbyte;
      end
    end
  end

  // ----------------------------------------------------------------
  // Accumulator and status word
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_q           <= CPR_RST_ACC;
      high_q          <= CPR_RST_RESULT_HI;
      carry_flag      <= CPR_RST_PSW[CPR_PSW_CARRY];
      half_carry_flag <= CPR_RST_PSW[CPR_PSW_HALF];
      overflow_flag   <= CPR_RST_PSW[CPR_PSW_OVERFLOW];
      parity_q        <= CPR_RST_PSW[CPR_PSW_PARITY];
    end else begin
      acc_q           <= next_acc;
      high_q          <= next_high;
      carry_flag      <= next_carry;
      half_carry_flag <= next_half;
      overflow_flag   <= next_ovf;
      parity_q        <= next_parity;
    end
  end

  // User flags and bank select change only through a bus write.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      user_flag_a      <= CPR_RST_PSW[CPR_PSW_USER_A];
      user_flag_b      <= CPR_RST_PSW[CPR_PSW_USER_B];
      bank_select_high <= CPR_RST_PSW[CPR_PSW_BANK_HI];
      bank_select_low  <= CPR_RST_PSW[CPR_PSW_BANK_LO];
    end else if (wr_psw) begin
      user_flag_a      <= wbyte[CPR_PSW_USER_A];
      user_flag_b      <= wbyte[CPR_PSW_USER_B];
      bank_select_high <= wbyte[CPR_PSW_BANK_HI];
      bank_select_low  <= wbyte[CPR_PSW_BANK_LO];
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all taken straight from flops
  // ----------------------------------------------------------------
  assign accumulator         = acc_q;
  assign result_high         = high_q;
  assign data_pointer        = {pointer_high, pointer_low};
  assign program_status_word = psw_image;
  assign bank_base_addr      = {bank_select_high, bank_select_low, 3'h0};

endmodule : cpr_core_regs

`default_nettype wire

// >>> hdl/cpr_pkg.sv
// Package with the register map, status word layout and operation codes of the core register set.
package cpr_pkg;

  // ----------------------------------------------------------------
  // Register indexes (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] CPR_IDX_STACK_TOP  = 8'h81;
  localparam logic [7:0] CPR_IDX_DP_LOW     = 8'h82;
  localparam logic [7:0] CPR_IDX_DP_HIGH    = 8'h83;
  localparam logic [7:0] CPR_IDX_PSW        = 8'hd0;
  localparam logic [7:0] CPR_IDX_ACC        = 8'he0;
  localparam logic [7:0] CPR_IDX_RESULT_HI  = 8'hf0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CPR_RST_STACK_TOP  = 8'h07;
  localparam logic [7:0] CPR_RST_DP_LOW     = 8'h00;
  localparam logic [7:0] CPR_RST_DP_HIGH    = 8'h00;
  localparam logic [7:0] CPR_RST_PSW        = 8'h00;
  localparam logic [7:0] CPR_RST_ACC        = 8'h00;
  localparam logic [7:0] CPR_RST_RESULT_HI  = 8'h00;

  // ----------------------------------------------------------------
  // Program status word field positions
  // ----------------------------------------------------------------
  localparam int CPR_PSW_CARRY     = 7;
  localparam int CPR_PSW_HALF      = 6;
  localparam int CPR_PSW_USER_A    = 5;
  localparam int CPR_PSW_BANK_HI   = 4;
  localparam int CPR_PSW_BANK_LO   = 3;
  localparam int CPR_PSW_OVERFLOW  = 2;
  localparam int CPR_PSW_USER_B    = 1;
  localparam int CPR_PSW_PARITY    = 0;

  // ----------------------------------------------------------------
  // Bank geometry: eight bytes per working register bank
  // ----------------------------------------------------------------
  localparam int CPR_BANK_SHIFT    = 3;

  // ----------------------------------------------------------------
  // Arithmetic operation codes on the core port
  // ----------------------------------------------------------------
  localparam logic [2:0] CPR_OP_NONE        = 3'h0;
  localparam logic [2:0] CPR_OP_ADD         = 3'h1;
  localparam logic [2:0] CPR_OP_ADD_CARRY   = 3'h2;
  localparam logic [2:0] CPR_OP_SUB_BORROW  = 3'h3;
  localparam logic [2:0] CPR_OP_MULTIPLY    = 3'h4;
  localparam logic [2:0] CPR_OP_DIVIDE      = 3'h5;

endpackage : cpr_pkg

// >>> testbench/cpr_core_regs_bench.sv
// Self-checking bench of the core register set.
`timescale 1ns/1ns
`default_nettype none
module cpr_core_regs_bench
  import cpr_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals and case table
  // ----------------------------------------------------------------
  localparam logic [11:0] A_SP  = {2'b00, CPR_IDX_STACK_TOP, 2'b00};
  localparam logic [11:0] A_DL  = {2'b00, CPR_IDX_DP_LOW, 2'b00};
  localparam logic [11:0] A_DH  = {2'b00, CPR_IDX_DP_HIGH, 2'b00};
  localparam logic [11:0] A_PSW = {2'b00, CPR_IDX_PSW, 2'b00};
  localparam logic [11:0] A_ACC = {2'b00, CPR_IDX_ACC, 2'b00};
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        stack_push = 1'b0, stack_pop = 1'b0, pready, pslverr, er;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, prdata, rd;
  logic [3:0]  pstrb = 4'hf;
  logic [2:0]  op_code = 3'h0;
  logic [7:0]  op_operand = 8'h00, stack_access_addr, accumulator, result_high, program_status_word;
  logic [15:0] data_pointer;
  logic [4:0]  bank_base_addr;
  int          n_fail = 0, num_checks = 0;
  // Fields: op, a, b, carry in, result, high result, {0, carry, half carry, overflow}.
  logic [43:0] tab [9] = '{44'h1_7f_01_0_80_00_3, 44'h1_ff_01_0_00_00_6, 44'h2_10_20_1_31_00_0,
    44'h3_00_01_0_ff_00_6, 44'h3_80_01_0_7f_00_3, 44'h4_10_10_0_00_01_1, 44'h4_03_04_0_0c_00_0,
    44'h5_0d_04_0_03_01_0, 44'h5_0d_00_0_0d_01_1};

  cpr_core_regs #(.ADDR_W(12)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .op_code(op_code), .op_operand(op_operand), .stack_push(stack_push),
    .stack_pop(stack_pop), .stack_access_addr(stack_access_addr), .accumulator(accumulator),
    .result_high(result_high), .data_pointer(data_pointer), .program_status_word(program_status_word),
    .bank_base_addr(bank_base_addr));

  initial begin
    forever #4 pclk = ~pclk;
  end
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic give_verdict();
    if (n_fail == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // The loop bound keeps a slave that never answers from hanging the run.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 16) begin
      n_fail++;
      give_verdict();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask : apb
  task automatic rdchk(input string nm, input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    chk(nm, rd[15:0], {8'h00, e});
  endtask : rdchk
  task automatic op(input logic [2:0] c, input logic [7:0] b);
    @(posedge pclk);
    op_code <= c;
    op_operand <= b;
    @(posedge pclk);
    op_code <= CPR_OP_NONE;
    #1;
  endtask : op
  task automatic stk(input logic [2:0] seq, input logic [7:0] e_addr, input logic [7:0] e_top);
    foreach (seq[i]) begin
      @(posedge pclk);
      stack_push <= seq[i];
      stack_pop <= ~seq[i];
    end
    @(posedge pclk);
    stack_push <= 1'b0;
    stack_pop <= 1'b0;
    #1;
    chk("stack addr", {8'h00, stack_access_addr}, {8'h00, e_addr});
    rdchk("stack top", A_SP, e_top);
  endtask : stk
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    chk("stack addr", {8'h00, stack_access_addr}, {8'h00, CPR_RST_STACK_TOP});
    rdchk("stack top", A_SP, CPR_RST_STACK_TOP);
    rdchk("ptr low", A_DL, CPR_RST_DP_LOW);
    rdchk("ptr high", A_DH, CPR_RST_DP_HIGH);
    rdchk("status", A_PSW, CPR_RST_PSW);
    rdchk("acc", A_ACC, CPR_RST_ACC);
    apb(1'b0, 12'h004, 8'h00);
    chk("unmapped err", {15'h0000, er}, 16'h0001);
    apb(1'b1, A_ACC | 12'h001, 8'h55);
    chk("unaligned err", {15'h0000, er}, 16'h0001);
  endtask : t_reset
  task automatic t_regs();
    apb(1'b1, A_DL, 8'h34);
    apb(1'b1, A_DH, 8'h12);
    pstrb <= 4'h0;
    apb(1'b1, A_DL, 8'hff);
    pstrb <= 4'hf;
    chk("pointer", data_pointer, 16'h1234);
    rdchk("ptr low", A_DL, 8'h34);
    apb(1'b1, A_ACC, 8'h03);
    rdchk("acc", A_ACC, 8'h03);
    apb(1'b1, A_PSW, 8'hff);
    rdchk("status", A_PSW, 8'hfe);
    for (int b = 0; b < 4; b++) begin
      apb(1'b1, A_PSW, {3'b000, b[1:0], 3'b000});
      chk("bank base", {11'h000, bank_base_addr}, {11'h000, b[1:0], 3'b000});
    end
  endtask : t_regs
  task automatic t_alu();
    logic [43:0] t;
    for (int i = 0; i < 9; i++) begin
      t = tab[i];
      apb(1'b1, A_PSW, {t[20], 2'b11, 2'b00, 1'b1, 2'b00});
      apb(1'b1, A_ACC, t[39:32]);
      op(t[42:40], t[31:24]);
      chk("acc", {8'h00, accumulator}, {8'h00, t[19:12]});
      chk("high", {8'h00, result_high}, {8'h00, t[11:4]});
      chk("flags", {8'h00, program_status_word}, {8'h00, t[2:1], 3'b100, t[0], 1'b0, ^t[19:12]});
    end
    // Back-to-back adds: the second must build on the first.
    apb(1'b1, A_ACC, 8'h01);
    @(posedge pclk);
    op_code <= CPR_OP_ADD;
    op_operand <= 8'h01;
    @(posedge pclk);
    op_operand <= 8'h02;
    @(posedge pclk);
    op_code <= CPR_OP_NONE;
    #1;
    chk("acc chain", {8'h00, accumulator}, 16'h0004);
  endtask : t_alu

  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    t_reset();
    stk(3'b111, 8'h0a, 8'h0a);
    stk(3'b001, 8'h09, 8'h09);
    apb(1'b1, A_SP, 8'hff);
    stk(3'b100, 8'hff, 8'hfe);
    stk(3'b000, 8'hfc, 8'hfb);
    t_regs();
    t_alu();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    t_reset();
    give_verdict();
  end
endmodule : cpr_core_regs_bench
`default_nettype wire

// >>> testbench/cpr_core_regs_monitor.sv
// Concurrent checks on the ports of the core register set.
`timescale 1ns/1ns
`default_nettype none
module cpr_core_regs_monitor
  import cpr_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [3:0]        pstrb,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic [2:0]        op_code,
  input wire logic [7:0]        op_operand,
  input wire logic              stack_push,
  input wire logic              stack_pop,
  input wire logic [7:0]        stack_access_addr,
  input wire logic [7:0]        accumulator,
  input wire logic [7:0]        result_high,
  input wire logic [15:0]       data_pointer,
  input wire logic [7:0]        program_status_word,
  input wire logic [4:0]        bank_base_addr
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] A_DL = ADDR_W'({CPR_IDX_DP_LOW, 2'b00});
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_push; stack_push; endsequence
  sequence s_pop; stack_pop && !stack_push; endsequence
  property p_rst_stack; $rose(presetn) |-> stack_access_addr == CPR_RST_STACK_TOP; endproperty
  a_rst_stack: assert property (p_rst_stack) else $error("stack address off after reset");
  property p_push2; s_push ##1 s_push |=> stack_access_addr == $past(stack_access_addr) + 8'h01; endproperty
  a_push2: assert property (p_push2) else $error("push did not step the stack up");
  property p_pop2; s_pop ##1 s_pop |=> stack_access_addr == $past(stack_access_addr) - 8'h01; endproperty
  a_pop2: assert property (p_pop2) else $error("pop did not step the stack down");
  property p_pop_push; s_pop ##1 s_push |=> stack_access_addr == $past(stack_access_addr); endproperty
  a_pop_push: assert property (p_pop_push) else $error("push after pop at wrong place");
  property p_add; op_code == CPR_OP_ADD |=> {program_status_word[CPR_PSW_CARRY], accumulator} ==
    {1'b0, $past(accumulator)} + {1'b0, $past(op_operand)}; endproperty
  a_add: assert property (p_add) else $error("add sum or carry wrong");
  property p_mul; op_code == CPR_OP_MULTIPLY |=> {result_high, accumulator} == {8'h00, $past(accumulator)} *
    {8'h00, $past(op_operand)} && program_status_word[CPR_PSW_OVERFLOW] == (result_high != 8'h00); endproperty
  a_mul: assert property (p_mul) else $error("multiply product or overflow wrong");
  property p_div0; op_code == CPR_OP_DIVIDE && op_operand == 8'h00 |=>
    program_status_word[CPR_PSW_OVERFLOW] && $stable(accumulator) && $stable(result_high); endproperty
  a_div0: assert property (p_div0) else $error("divide by zero handled wrongly");
  property p_parity; program_status_word[CPR_PSW_PARITY] == ^accumulator; endproperty
  a_parity: assert property (p_parity) else $error("parity flag wrong");
  property p_ready; psel && !penable |=> pready ##1 !pready; endproperty
  a_ready: assert property (p_ready) else $error("ready not a single pulse after setup");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_dp; psel && penable && pwrite && pready && !pslverr && pstrb[0] && paddr == A_DL |=>
    data_pointer[7:0] == $past(pwdata[7:0]); endproperty
  a_dp: assert property (p_dp) else $error("pointer low byte not written");
  // Only a bus write may move the user flags, so anything else must leave them alone.
  property p_user; !$past(psel && penable && pwrite) |->
    $stable({program_status_word[CPR_PSW_USER_A], program_status_word[CPR_PSW_USER_B]}); endproperty
  a_user: assert property (p_user) else $error("user flag changed by hardware");
endmodule : cpr_core_regs_monitor

bind cpr_core_regs cpr_core_regs_monitor #(.ADDR_W(ADDR_W)) u_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .op_code(op_code), .op_operand(op_operand), .stack_push(stack_push),
  .stack_pop(stack_pop), .stack_access_addr(stack_access_addr), .accumulator(accumulator),
  .result_high(result_high), .data_pointer(data_pointer), .program_status_word(program_status_word),
  .bank_base_addr(bank_base_addr));
`default_nettype wire
